//--- pkg/asr_consts.vh
// timing and frame constants for the converter read-out host
`ifndef ASR_CONSTS_VH
`define ASR_CONSTS_VH
// system clock period in ns (125 MHz)
`define ASR_CLK_PERIOD_NS 8
// frame length in serial clock pulses
`define ASR_FRAME_BITS 16
// number of leading zero bits in a frame
`define ASR_LEAD_ZEROS 4
// result width
`define ASR_RESULT_BITS 12
// serial clock half period in ns (10 MHz top rate -> 50 ns)
`define ASR_SCLK_HALF_NS 50
// serial clock half period in system cycles, rounded up (least time)
`define ASR_SCLK_HALF_CYC ((`ASR_SCLK_HALF_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
// conversion-start low pulse width in ns
`define ASR_CONV_LOW_NS 40
// conversion-start low pulse in cycles, rounded up
`define ASR_CONV_LOW_CYC ((`ASR_CONV_LOW_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
// longest conversion time in ns
`define ASR_CONV_MAX_NS 8000
// conversion timeout in cycles, rounded down
`define ASR_CONV_MAX_CYC (`ASR_CONV_MAX_NS / `ASR_CLK_PERIOD_NS)
// settle time before the next conversion start in ns
`define ASR_SETTLE_NS 400
// settle time in cycles, rounded up
`define ASR_SETTLE_CYC ((`ASR_SETTLE_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
// busy is awaited for this many cycles, plus four for the synchroniser, before the host moves on
`define ASR_BUSY_WAIT_CYC 4
`endif

//--- src/asr_sync3.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module asr_sync3 (
    input wire sys_clk_i,
    input wire srst_i,
    input wire async_i,
    output wire level_o
);
    reg s1_reg; // first stage, read only by s2
    reg s2_reg; // second stage
    reg s3_reg; // third stage
    reg lvl_reg; // filtered level

    // shift chain; level follows once stages two and three agree
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            lvl_reg <= 1'b0;
        end else begin
            s1_reg <= async_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                lvl_reg <= s3_reg;
            end
        end
    end

    assign level_o = lvl_reg;
endmodule // asr_sync3

//--- src/asr_host.v
// host controller: starts conversions and reads 16-bit frames
//
// Notes on behaviour
// RL1: device shifts each bit on falling clock
// RL2: first leading zero appears after first rise
// RL3: master gives sixteen clock pulses per result
// RL4: frame is four zeros, then twelve bits
// RL5: bottom bit arrives on fifteenth falling edge
// RL6: sixteenth falling edge ends frame, output floats
// RL7: hold clock low after the sixteenth bit
// RL8: extra pulses restart shifting; output stays driven
// RL9: device counts clock edges for bit position
// RL10: start fall resets counter if clock low
// RL11: clock low whenever conversion start is low
// RL12: no start fall during a read
// RL13: clock may pause between bytes, held low
// RL14: serial clock at most 10 MHz
// RL15: master supplies every serial clock pulse
// RL16: wait for busy low before reading
// RL17: select bit gates the clock high
// RL18: msb first, no reversal needed here
// RL19: clock polarity 0, phase 1 style
// RL20: busy rises on start, falls within 8 us
// RL21: device output floats until first read edge
`timescale 1ns/100ps
`include "asr_consts.vh"
module asr_host #(
    parameter FRAME_BITS = `ASR_FRAME_BITS,
    parameter RESULT_BITS = `ASR_RESULT_BITS,
    parameter HALF_CYC = `ASR_SCLK_HALF_CYC,
    parameter CONV_MAX_CYC = `ASR_CONV_MAX_CYC,
    parameter BYTE_PAUSE_CYC = 0
) (
    input wire sys_clk_i,
    input wire srst_i,
    input wire start_i,
    input wire select_i,
    output wire ready_o,
    output wire [RESULT_BITS-1:0] result_o,
    output wire result_valid_o,
    output wire frame_error_o,
    output wire timeout_o,
    output wire sclk_o,
    output wire conversion_start_n_o,
    input wire serial_result_out_i,
    input wire busy_i
);
    // states, one-hot
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_CONV = 7'h02;
    localparam [6:0] ST_BUSYW = 7'h04;
    localparam [6:0] ST_WAITD = 7'h08;
    localparam [6:0] ST_HIGH = 7'h10;
    localparam [6:0] ST_LOW = 7'h20;
    localparam [6:0] ST_SETL = 7'h40;

    // integer copies of the header counts, narrowed on purpose below
    localparam integer CONVL_I = `ASR_CONV_LOW_CYC;
    localparam integer SETL_I = `ASR_SETTLE_CYC;
    localparam integer BUSYW_I = `ASR_BUSY_WAIT_CYC;
    localparam integer ZERO_I = `ASR_LEAD_ZEROS;
    localparam [15:0] HALF_W = HALF_CYC[15:0];
    localparam [15:0] CONVL_W = CONVL_I[15:0];
    localparam [15:0] SETL_W = SETL_I[15:0];
    localparam [15:0] BUSYW_W = BUSYW_I[15:0];
    localparam [15:0] PAUSE_W = BYTE_PAUSE_CYC[15:0];
    localparam [15:0] CMAX_W = CONV_MAX_CYC[15:0];
    localparam [4:0] FRAME_W = FRAME_BITS[4:0];
    localparam [4:0] ZERO_W = ZERO_I[4:0];

    reg [6:0] state_reg;
    reg [6:0] state_next;
    reg [15:0] tmr_reg; // generic wait counter
    reg [15:0] tmr_next;
    reg [4:0] bit_reg; // pulses given in this frame
    reg [4:0] bit_next;
    reg [FRAME_BITS-1:0] shift_reg; // captured frame, msb first
    reg [FRAME_BITS-1:0] shift_next;
    reg sclk_reg; // serial clock drive
    reg sclk_next;
    reg conv_n_reg; // conversion start drive, active low
    reg conv_n_next;
    reg [RESULT_BITS-1:0] result_reg;
    reg [RESULT_BITS-1:0] result_next;
    reg valid_reg;
    reg valid_next;
    reg ferr_reg;
    reg ferr_next;
    reg tout_reg;
    reg tout_next;
    wire busy_s; // synchronised busy
    wire serial_result_out_s; // synchronised serial data

    // busy and data come from outside the clock domain
    asr_sync3 u_busy (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .async_i(busy_i),
        .level_o(busy_s)
    );
    asr_sync3 u_serial_result_out (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .async_i(serial_result_out_i),
        .level_o(serial_result_out_s)
    );

    // true when the wait counter has reached its target
    function tmr_done;
        input [15:0] t;
        input [15:0] lim;
        begin
            tmr_done = (t + 16'h0001 >= lim);
        end
    endfunction

    // next-state and datapath logic
    always @* begin
        state_next = state_reg;
        tmr_next = tmr_reg + 16'h0001;
        bit_next = bit_reg;
        shift_next = shift_reg;
        sclk_next = sclk_reg;
        conv_n_next = conv_n_reg;
        result_next = result_reg;
        valid_next = 1'b0;
        ferr_next = ferr_reg;
        tout_next = tout_reg;
        case (state_reg)
            ST_IDLE: begin
                // clock stays low between frames [RL7] [RL11]
                sclk_next = 1'b0;
                tmr_next = 16'h0000;
                if (start_i) begin
                    // start falls only with clock low, no read open [RL10] [RL12]
                    conv_n_next = 1'b0;
                    ferr_next = 1'b0;
                    tout_next = 1'b0;
                    state_next = ST_CONV;
                end
            end
            ST_CONV: begin
                // hold start low briefly, clock stays low [RL11]
                if (tmr_done(tmr_reg, CONVL_W)) begin
                    conv_n_next = 1'b1;
                    tmr_next = 16'h0000;
                    state_next = ST_BUSYW;
                end
            end
            ST_BUSYW: begin
                // allow for busy to be seen high through the synchroniser
                if (busy_s || tmr_done(tmr_reg, BUSYW_W + 16'h0004)) begin
                    tmr_next = 16'h0000;
                    state_next = ST_WAITD;
                end
            end
            ST_WAITD: begin
                // poll busy low before reading [RL16] [RL20]
                if (!busy_s) begin
                    tmr_next = 16'h0000;
                    bit_next = 5'h00;
                    state_next = ST_HIGH;
                    sclk_next = select_i; // select gates clock [RL17]
                end else if (tmr_done(tmr_reg, CMAX_W + 16'h0008)) begin
                    // overrun: flag it and skip the read, no clock in busy
                    tout_next = 1'b1; // [RL16]
                    tmr_next = 16'h0000;
                    state_next = ST_SETL;
                end
            end
            ST_HIGH: begin
                // clock high half; sample at the end, cpol 0 cpha 1 [RL19]
                if (tmr_done(tmr_reg, HALF_W)) begin
                    // bit held stable since last fall, or since the first rise for the first bit [RL1] [RL2]
                    shift_next = {shift_reg[FRAME_BITS-2:0], serial_result_out_s};
                    sclk_next = 1'b0;
                    bit_next = bit_reg + 5'h01;
                    tmr_next = 16'h0000;
                    state_next = ST_LOW;
                end
            end
            ST_LOW: begin
                // low half; pause after the first byte keeps clock low [RL13]
                if (bit_reg == FRAME_W) begin
                    // exactly sixteen pulses, no extras [RL3] [RL8] [RL6]
                    // msb arrives first so no reversal [RL18]
                    result_next = shift_reg[RESULT_BITS-1:0]; // [RL4] [RL5]
                    ferr_next = |shift_reg[FRAME_BITS-1:FRAME_BITS-ZERO_W];
                    valid_next = 1'b1;
                    tmr_next = 16'h0000;
                    state_next = ST_SETL;
                end else if (tmr_done(tmr_reg, HALF_W +
                             ((bit_reg[2:0] == 3'h0) ? PAUSE_W : 16'h0000))) begin
                    // every pulse is ours, limited to 10 MHz [RL15] [RL14]
                    sclk_next = select_i;
                    tmr_next = 16'h0000;
                    state_next = ST_HIGH;
                end
            end
            ST_SETL: begin
                // settle before next start may fall [RL12]
                if (tmr_done(tmr_reg, SETL_W)) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
                sclk_next = 1'b0;
                conv_n_next = 1'b1;
            end
        endcase
    end

    // state and datapath registers
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_reg <= ST_IDLE;
            tmr_reg <= 16'h0000;
            bit_reg <= 5'h00;
            shift_reg <= {FRAME_BITS{1'b0}};
            sclk_reg <= 1'b0;
            conv_n_reg <= 1'b1;
            result_reg <= {RESULT_BITS{1'b0}};
            valid_reg <= 1'b0;
            ferr_reg <= 1'b0;
            tout_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            sclk_reg <= sclk_next;
            conv_n_reg <= conv_n_next;
            result_reg <= result_next;
            valid_reg <= valid_next;
            ferr_reg <= ferr_next;
            tout_reg <= tout_next;
        end
    end

    assign ready_o = (state_reg == ST_IDLE);
    assign result_o = result_reg;
    assign result_valid_o = valid_reg;
    assign frame_error_o = ferr_reg;
    assign timeout_o = tout_reg;
    assign sclk_o = sclk_reg;
    assign conversion_start_n_o = conv_n_reg;
endmodule // asr_host

//--- sim/asr_dev_model.sv
// behavioural model of the converter's serial read-out port
`timescale 1ns/100ps
module asr_dev_model #(
    parameter CONV_NS = 200,
    parameter SLOW_NS = 2000
) (
    input wire sclk_i, // clock only ever comes from the host
    input wire conversion_start_n_i,
    input wire [11:0] value_i,
    input wire bad_lead_i,
    input wire slow_i, // overrun: conversion outlasts the host's wait limit
    output reg serial_result_out_o,
    output reg busy_o
);
    reg [15:0] frame_reg; // held result behind leading zeros
    integer edges; // falling clock edges seen in this frame
    // released at power-up; no pull, so level means nothing
    initial begin
        serial_result_out_o = 1'b1;
        busy_o = 1'b0;
        edges = 0;
        frame_reg = 16'h0000;
    end
    // start fall: busy up, counter cleared only with clock low
    always @(negedge conversion_start_n_i) begin
        busy_o = 1'b1;
        if (sclk_i == 1'b0) edges = 0;
        // an overrun keeps busy up past the host's shortened limit
        #(slow_i ? SLOW_NS : CONV_NS);
        frame_reg = {bad_lead_i, 3'h0, value_i};
        busy_o = 1'b0;
    end
    // first rise of a frame, or after sixteen, drives the top bit
    always @(posedge sclk_i) begin
        if (edges == 0 || edges == 16) begin
            edges = 0;
            serial_result_out_o = frame_reg[15];
        end
    end
    // falls one to fifteen move on one bit, the sixteenth flips the output; pauses just wait
    always @(negedge sclk_i) begin
        edges = edges + 1;
        if (edges < 16) #10 serial_result_out_o = frame_reg[15 - edges];
        else #10 serial_result_out_o = ~serial_result_out_o;
    end
endmodule // asr_dev_model

//--- sim/asr_host_checker.sv
// assertions on the host's serial clock and conversion start
`timescale 1ns/100ps
module asr_host_checker (
    input wire sys_clk_i,
    input wire srst_i,
    input wire select_i,
    input wire ready_o,
    input wire result_valid_o,
    input wire sclk_o,
    input wire conversion_start_n_o,
    input wire busy_i
);
    reg [4:0] pulses_reg; // clock rises since the last start fall
    reg sclk_d_reg; // clock level one cycle ago
    reg conv_d_reg; // start level one cycle ago
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);
    // count clock pulses between start falls
    always @(posedge sys_clk_i) begin
        sclk_d_reg <= sclk_o;
        conv_d_reg <= conversion_start_n_o;
        if (srst_i) begin
            pulses_reg <= 5'h00;
        end else if (conv_d_reg && !conversion_start_n_o) begin
            pulses_reg <= 5'h00;
        end else if (!sclk_d_reg && sclk_o) begin
            pulses_reg <= pulses_reg + 5'h01;
        end
    end
    AST_CLK_LOW_AT_START:
        assert property (!conversion_start_n_o |-> !sclk_o)
        else $error("clock high while start low");
    AST_START_BETWEEN_READS:
        assert property ($fell(conversion_start_n_o) |->
            pulses_reg == 5'h00 || pulses_reg == 5'h10)
        else $error("start fell inside a read");
    AST_HIGH_HALF:
        assert property ($rose(sclk_o) |-> sclk_o [*7])
        else $error("clock high half too short");
    AST_LOW_HALF:
        assert property ($fell(sclk_o) |-> !sclk_o [*7])
        else $error("clock low half too short");
    AST_IDLE_LOW:
        assert property (ready_o |-> !sclk_o)
        else $error("clock not low while idle");
    AST_READ_AFTER_BUSY:
        assert property ($rose(sclk_o) |-> !busy_i)
        else $error("clock pulse while busy");
    AST_SIXTEEN:
        assert property (result_valid_o |-> pulses_reg == 5'h10 && !sclk_o)
        else $error("result without sixteen pulses");
    AST_SELECT_GATE:
        assert property ($rose(sclk_o) |-> $past(select_i))
        else $error("clock pulse while deselected");
endmodule // asr_host_checker
bind asr_host asr_host_checker u_chk (
    .sys_clk_i, .srst_i, .select_i, .ready_o, .result_valid_o,
    .sclk_o, .conversion_start_n_o, .busy_i
);

//--- sim/asr_host_test.sv
// self-checking bench for the converter read-out host
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
    compares = compares + 1; \
    if ((g) !== (e)) begin \
        n_fail = n_fail + 1; \
        $display("Error %s expected %h seen %h", nm, e, g); \
    end \
end
module asr_host_test;
    reg sys_clk_i = 1'b0;
    reg srst_i = 1'b1; // held for the first 20 cycles
    reg start_i = 1'b0;
    reg select_i = 1'b1; // single device, always selected
    reg [11:0] value = 12'h000; // result the model will hold
    reg bad_lead = 1'b0; // model sends a one in the first lead bit
    reg slow = 1'b0; // model overruns the host's conversion limit
    wire ready_o, result_valid_o, frame_error_o, timeout_o;
    wire sclk_o, conversion_start_n_o, serial_result_out_i, busy_i;
    wire [11:0] result_o;
    integer n_fail = 0;
    integer compares = 0;
    integer n_conv = 0; // conversion starts seen on the wire
    always #4 sys_clk_i = ~sys_clk_i;
    always @(negedge conversion_start_n_o) n_conv = n_conv + 1;
    integer n_rise = 0; // serial clock rises seen on the wire
    always @(posedge sclk_o) n_rise = n_rise + 1;
    asr_host #(.CONV_MAX_CYC(50), .BYTE_PAUSE_CYC(20)) u_dut (
        .sys_clk_i, .srst_i, .start_i, .select_i, .ready_o, .result_o,
        .result_valid_o, .frame_error_o, .timeout_o, .sclk_o,
        .conversion_start_n_o, .serial_result_out_i, .busy_i
    );
    asr_dev_model u_dev (
        .sclk_i(sclk_o), .conversion_start_n_i(conversion_start_n_o),
        .value_i(value), .bad_lead_i(bad_lead), .slow_i(slow),
        .serial_result_out_o(serial_result_out_i), .busy_o(busy_i)
    );
    // print counts and verdict, then end the run
    task report_and_stop;
        begin
            $display("compares %0d n_fail %0d", compares, n_fail);
            if (n_fail == 0 && compares > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // one conversion and read; start held hold cycles while refused
    task do_read(input [11:0] v, input bad, input integer hold);
        integer n;
        integer c0;
        begin
            c0 = n_conv;
            @(posedge sys_clk_i);
            value <= v;
            bad_lead <= bad;
            start_i <= 1'b1;
            n = 0;
            @(posedge sys_clk_i);
            while (ready_o !== 1'b0 && n < 10) begin
                @(posedge sys_clk_i);
                n = n + 1;
            end
            `CHK("taken", 1'b0, ready_o)
            repeat (hold) @(posedge sys_clk_i);
            start_i <= 1'b0;
            n = 0;
            while (result_valid_o !== 1'b1 && n < 2000) begin
                @(posedge sys_clk_i);
                n = n + 1;
            end
            `CHK("valid", 1'b1, result_valid_o)
            `CHK("result", v, result_o)
            `CHK("lead_error", bad, frame_error_o)
            `CHK("timeout", 1'b0, timeout_o)
            `CHK("starts", 1, n_conv - c0)
            n = 0;
            while (ready_o !== 1'b1 && n < 200) begin
                @(posedge sys_clk_i);
                n = n + 1;
            end
            `CHK("ready", 1'b1, ready_o)
        end
    endtask
    // an overrun conversion is flagged and not clocked, then a good read
    task t_timeout;
        integer n;
        integer c0;
        integer r0;
        begin
            c0 = n_conv;
            r0 = n_rise;
            @(posedge sys_clk_i);
            slow <= 1'b1;
            start_i <= 1'b1;
            repeat (2) @(posedge sys_clk_i);
            start_i <= 1'b0;
            n = 0;
            while (ready_o !== 1'b1 && n < 400) begin
                @(posedge sys_clk_i);
                n = n + 1;
            end
            `CHK("overrun_ready", 1'b1, ready_o)
            `CHK("overrun_flag", 1'b1, timeout_o)
            `CHK("overrun_pulses", 0, n_rise - r0)
            `CHK("overrun_starts", 1, n_conv - c0)
            n = 0;
            while (busy_i !== 1'b0 && n < 400) begin
                @(posedge sys_clk_i);
                n = n + 1;
            end
            `CHK("overrun_end", 1'b0, busy_i)
            slow <= 1'b0;
            do_read(12'h6B2, 1'b0, 0);
        end
    endtask
    // mixed pattern through both bytes with a pause
    task t_plain;
        do_read(12'hA5C, 1'b0, 0);
    endtask
    // all ones, all zeros, only top and bottom bits
    task t_extremes;
        begin
            do_read(12'hFFF, 1'b0, 0);
            do_read(12'h000, 1'b0, 0);
            do_read(12'h801, 1'b0, 0);
        end
    endtask
    // a set lead bit is flagged, then cleared by a good frame
    task t_lead_error;
        begin
            do_read(12'h3C3, 1'b1, 0);
            do_read(12'h3C3, 1'b0, 0);
        end
    endtask
    // start kept high while busy must not start a second one
    task t_refused;
        do_read(12'h5A5, 1'b0, 30);
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        t_plain;
        t_extremes;
        t_lead_error;
        t_timeout;
        t_refused;
        report_and_stop;
    end
    // watchdog: eight reads and an overrun need well under this
    initial begin
        #200000;
        n_fail = n_fail + 1;
        report_and_stop;
    end
endmodule // asr_host_test
